// [lvrc_cfg.svh]
`ifndef LVRC_CFG_SVH
`define LVRC_CFG_SVH

// ==========================================================
// register offsets (byte addresses on the plain register port)
`define LVRC_ADDR_STATUS   8'h00
`define LVRC_ADDR_CONFIG   8'h01
`define LVRC_ADDR_INT_STAT 8'h02
`define LVRC_ADDR_INT_EN   8'h03
`define LVRC_ADDR_INT_CLR  8'h04

// ==========================================================
// field positions
`define LVRC_STAT_BELOW_BIT 0
`define LVRC_STAT_RSTREQ_BIT 1
`define LVRC_CFG_PWRD_BIT  0
`define LVRC_CFG_RSTD_BIT  1
`define LVRC_CFG_STOP_BIT  2
`define LVRC_CFG_LVLSEL_BIT 3
`define LVRC_EV_FALL_BIT   0
`define LVRC_EV_RISE_BIT   1
`define LVRC_EV_RST_BIT    2

// ==========================================================
// reset values
`define LVRC_CONFIG_RST    8'h00
`define LVRC_INT_EN_RST    8'h00

`endif

// [lvrc_pkg.sv]
package lvrc_pkg;

    typedef enum logic [1:0] {
        LVRC_IDLE,
        LVRC_TRIPPED
    } lvrc_state_e;

    typedef struct packed {
        logic pwr_disable;
        logic rst_disable;
        logic stop_enable;
        logic level_select;
    } lvrc_cfg_s;

    typedef struct packed {
        logic in_stop;
        logic in_wait;
    } lvrc_mode_s;

    typedef logic [7:0] lvrc_byte_t;

endpackage

// [lvrc_sync.sv]
`timescale 1ns/1ps

module lvrc_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // ==========================================================
    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // lvrc_sync

// [lvrc_irq.sv]
`timescale 1ns/1ps
`include "lvrc_cfg.svh"

module lvrc_irq
    import lvrc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [2:0] events,
    input  wire logic       en_wr,
    input  wire logic       clr_wr,
    input  wire logic [2:0] wdata,
    output logic      [2:0] status_q,
    output logic      [2:0] enable_q,
    output logic            irq
);

    // ==========================================================
    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= 3'h0;
        end else begin
            status_q <= (status_q & ~(clr_wr ? wdata : 3'h0)) | events;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_q <= 3'(`LVRC_INT_EN_RST);
        end else if (en_wr) begin
            enable_q <= wdata;
        end
    end

    assign irq = |(status_q & enable_q);

endmodule // lvrc_irq

// [lvrc_top.sv]
`timescale 1ns/1ps
`include "lvrc_cfg.svh"

module lvrc_top
    import lvrc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       cmp_below_fall,
    input  wire logic       cmp_above_rise,
    input  wire logic       in_wait,
    input  wire logic       in_stop,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            monitor_enable,
    output logic            level_select,
    output logic            reset_request,
    output logic            mon_irq
);

    lvrc_cfg_s   cfg_q;
    lvrc_mode_s  mode;
    lvrc_state_e state_q;
    logic        below_s;
    logic        above_s;
    logic        active;
    logic        flag_q;
    logic        flag_d;
    logic        once_q;
    logic        trip;
    logic [2:0]  events;
    logic [2:0]  int_stat;
    logic [2:0]  int_en;
    logic        wr_cfg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // synchronise comparator outputs
    lvrc_sync u_sync_fall (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (cmp_below_fall),
        .sync_out (below_s)
    );

    lvrc_sync u_sync_rise (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (cmp_above_rise),
        .sync_out (above_s)
    );

    // ==========================================================
    // configuration; power and stop bits take one write only, as in
    // a write-once option byte, the other two any number of writes
    assign wr_cfg = reg_wr && hit(reg_addr, `LVRC_ADDR_CONFIG);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_q  <= lvrc_cfg_s'(4'(`LVRC_CONFIG_RST));
            once_q <= 1'b0;
        end else if (wr_cfg) begin
            cfg_q.rst_disable  <= reg_wdata[`LVRC_CFG_RSTD_BIT];
            cfg_q.level_select <= reg_wdata[`LVRC_CFG_LVLSEL_BIT];
            if (!once_q) begin
                cfg_q.pwr_disable <= reg_wdata[`LVRC_CFG_PWRD_BIT];
                cfg_q.stop_enable <= reg_wdata[`LVRC_CFG_STOP_BIT];
                once_q            <= 1'b1;
            end
        end
    end

    // ==========================================================
    // activity: wait mode leaves the monitor running, stop needs opt-in
    assign mode.in_stop = in_stop;
    assign mode.in_wait = in_wait;
    assign active = !cfg_q.pwr_disable
                 && (!mode.in_stop || cfg_q.stop_enable);

    assign monitor_enable = active;
    // the analog side moves its threshold on this; selecting the
    // higher level makes a low supply read below at once
    assign level_select = cfg_q.level_select;

    // ==========================================================
    // hysteresis flag
    always_comb begin
        flag_d = flag_q;
        if (active && below_s) begin
            flag_d = 1'b1;
        end else if (active && above_s) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ==========================================================
    // reset request; rst_n from the reset controller does not clear
    // the tripped state, otherwise the request would drop while held;
    // an unknown power-up code falls to idle through the default item
    assign trip = active && !cfg_q.rst_disable && below_s;

    always_ff @(posedge mclk) begin
        unique case (state_q)
            LVRC_IDLE: begin
                if (trip) begin
                    state_q <= LVRC_TRIPPED;
                end
            end
            LVRC_TRIPPED: begin
                if (above_s || !active || cfg_q.rst_disable) begin
                    state_q <= LVRC_IDLE;
                end
            end
            default: begin
                state_q <= LVRC_IDLE;
            end
        endcase
    end

    assign reset_request = (state_q == LVRC_TRIPPED);

    // ==========================================================
    // software event bits; the block drives no processor interrupt line
    // of its own, mon_irq only mirrors these enabled status bits
    assign events[`LVRC_EV_FALL_BIT] = flag_d && !flag_q;
    assign events[`LVRC_EV_RISE_BIT] = !flag_d && flag_q;
    assign events[`LVRC_EV_RST_BIT]  = trip && (state_q != LVRC_TRIPPED);

    lvrc_irq u_irq (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .events   (events),
        .en_wr    (reg_wr && hit(reg_addr, `LVRC_ADDR_INT_EN)),
        .clr_wr   (reg_wr && hit(reg_addr, `LVRC_ADDR_INT_CLR)),
        .wdata    (reg_wdata[2:0]),
        .status_q (int_stat),
        .enable_q (int_en),
        .irq      (mon_irq)
    );

    // ==========================================================
    // read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LVRC_ADDR_STATUS:
                    reg_rdata <= {6'h00, reset_request, flag_q};
                `LVRC_ADDR_CONFIG:
                    reg_rdata <= {4'h0, cfg_q.level_select, cfg_q.stop_enable,
                                  cfg_q.rst_disable, cfg_q.pwr_disable};
                `LVRC_ADDR_INT_STAT:
                    reg_rdata <= {5'h00, int_stat};
                `LVRC_ADDR_INT_EN:
                    reg_rdata <= {5'h00, int_en};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // lvrc_top

// [lvrc_props.sv]
`timescale 1ns/1ps
`include "lvrc_cfg.svh"

module lvrc_props (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cmp_below_fall,
    input wire logic       cmp_above_rise,
    input wire logic       in_stop,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       monitor_enable,
    input wire logic       level_select,
    input wire logic       reset_request
);
    // ==========
    // checks
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_req_cause: assert property ($rose(reset_request) |-> $past(cmp_below_fall, 3))
        else $error("reset request without a trip");
    a_req_hold: assert property ($fell(reset_request) && $past(monitor_enable) && !$past(reg_wr)
        && !$past(reg_wr, 2) |-> $past(cmp_above_rise, 3))
        else $error("reset request dropped below rising trip");
    a_status_read: assert property (reg_rd && reg_addr == `LVRC_ADDR_STATUS |=>
        reg_rdata[7:2] == 6'h00 && reg_rdata[1] == $past(reset_request))
        else $error("status read mismatch");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (reg_rd && reg_addr > `LVRC_ADDR_INT_CLR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_level_write: assert property (reg_wr && reg_addr == `LVRC_ADDR_CONFIG |=>
        level_select == $past(reg_wdata[`LVRC_CFG_LVLSEL_BIT]))
        else $error("level select write lost");
    a_rst_values: assert property ($rose(rst_n) |-> !level_select && reg_rdata == 8'h00)
        else $error("bad values after reset");
    a_enable_reset: assert property ($rose(rst_n) && !in_stop |-> monitor_enable)
        else $error("monitor off after reset");
endmodule // lvrc_props

bind lvrc_top lvrc_props i_props (.mclk(mclk), .rst_n(rst_n), .cmp_below_fall(cmp_below_fall),
    .cmp_above_rise(cmp_above_rise), .in_stop(in_stop), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .monitor_enable(monitor_enable), .level_select(level_select), .reset_request(reset_request));

// [lvrc_supply_model.sv]
`timescale 1ns/1ps

// ==========
// comparator pair; thresholds are arbitrary stand-ins
module lvrc_supply_model #(
    parameter logic [15:0] FALL_LO = 16'h0960,
    parameter logic [15:0] RISE_LO = 16'h09c4,
    parameter logic [15:0] FALL_HI = 16'h0af0,
    parameter logic [15:0] RISE_HI = 16'h0b54
) (
    input  wire logic [15:0] mv,
    input  wire logic        powered,
    input  wire logic        level_hi,
    output logic             below_fall,
    output logic             above_rise
);
    logic [15:0] fall_mv;
    logic [15:0] rise_mv;
    assign fall_mv = level_hi ? FALL_HI : FALL_LO;
    assign rise_mv = level_hi ? RISE_HI : RISE_LO;
    // an unpowered comparator reports nothing at all
    assign below_fall = powered && (mv < fall_mv);
    assign above_rise = powered && (mv > rise_mv);
endmodule // lvrc_supply_model

// [lvrc_tb_top.sv]
`timescale 1ns/1ps
`include "lvrc_cfg.svh"

module lvrc_tb_top;
    import lvrc_pkg::*;
    typedef struct { lvrc_byte_t cfg; logic [15:0] mv; lvrc_byte_t exp; } lvrc_row_s;
    localparam logic [15:0] V_LOW = 16'h08fc, V_MID = 16'h0992;
    localparam logic [15:0] V_GAP = 16'h0a28, V_HIGH = 16'h0bb8;
    logic        mclk, rst_n, cmp_below_fall, cmp_above_rise, in_wait, in_stop;
    logic        reg_wr, reg_rd, monitor_enable, level_select, reset_request, mon_irq;
    lvrc_byte_t  reg_addr, reg_wdata, reg_rdata;
    logic [15:0] mv;
    int          fail_count, n_tests;
    lvrc_row_s   rows [11] = '{'{8'h02, V_MID, 8'h00}, '{8'h02, V_LOW, 8'h01},
        '{8'h02, V_MID, 8'h01}, '{8'h02, V_HIGH, 8'h00}, '{8'h00, V_LOW, 8'h03},
        '{8'h00, V_MID, 8'h03}, '{8'h00, V_HIGH, 8'h00}, '{8'h08, V_GAP, 8'h03},
        '{8'h0a, V_GAP, 8'h01}, '{8'h00, V_LOW, 8'h03}, '{8'h00, V_HIGH, 8'h00}};

    always #10 mclk = ~mclk;

    lvrc_top i_dut (.mclk(mclk), .rst_n(rst_n), .cmp_below_fall(cmp_below_fall),
        .cmp_above_rise(cmp_above_rise), .in_wait(in_wait), .in_stop(in_stop),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .monitor_enable(monitor_enable),
        .level_select(level_select), .reset_request(reset_request), .mon_irq(mon_irq));
    lvrc_supply_model i_model (.mv(mv), .powered(monitor_enable), .level_hi(level_select),
        .below_fall(cmp_below_fall), .above_rise(cmp_above_rise));

    // ==========
    // helpers
    task automatic chk(input lvrc_byte_t got, input lvrc_byte_t exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input lvrc_byte_t a, input lvrc_byte_t d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input lvrc_byte_t a, input lvrc_byte_t exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        chk(reg_rdata, exp);
    endtask
    task automatic rst_pulse;
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========
    // sequence
    initial begin
        cyc(5000);
        fail_count++;
        end_of_test();
    end

    initial begin
        {mclk, rst_n, in_stop, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {fail_count, n_tests} = '0;
        in_wait = 1'b1;
        mv = V_HIGH;
        cyc(12);
        rst_n <= 1'b1;
        rd(`LVRC_ADDR_STATUS, 8'h00);
        for (int i = 0; i < 11; i++) begin
            wr(`LVRC_ADDR_CONFIG, rows[i].cfg);
            mv <= rows[i].mv;
            cyc(6);
            rd(`LVRC_ADDR_STATUS, rows[i].exp);
            chk({7'h00, mon_irq}, 8'h00);
        end
        wr(`LVRC_ADDR_INT_CLR, 8'h07);
        wr(`LVRC_ADDR_INT_EN, 8'h01);
        mv <= V_LOW;
        cyc(6);
        chk({7'h00, mon_irq}, 8'h01);
        rd(`LVRC_ADDR_INT_STAT, 8'h05);
        wr(`LVRC_ADDR_INT_EN, 8'h00);
        chk({7'h00, mon_irq}, 8'h00);
        wr(`LVRC_ADDR_INT_EN, 8'h01);
        chk({7'h00, mon_irq}, 8'h01);
        rd(`LVRC_ADDR_INT_EN, 8'h01);
        wr(`LVRC_ADDR_INT_CLR, 8'h05);
        chk({7'h00, mon_irq}, 8'h00);
        mv <= V_HIGH;
        cyc(6);
        rd(`LVRC_ADDR_INT_STAT, 8'h02);
        wr(`LVRC_ADDR_INT_EN, 8'h00);
        wr(`LVRC_ADDR_CONFIG, 8'h02);
        mv <= V_LOW;
        cyc(6);
        mv <= V_MID;
        cyc(6);
        rst_pulse();
        rd(`LVRC_ADDR_STATUS, 8'h00);
        in_stop <= 1'b1;
        wr(`LVRC_ADDR_CONFIG, 8'h04);
        chk({7'h00, monitor_enable}, 8'h01);
        // power and stop bits are locked by now, level select is not
        wr(`LVRC_ADDR_CONFIG, 8'h09);
        chk({6'h00, monitor_enable, level_select}, 8'h03);
        rd(`LVRC_ADDR_CONFIG, 8'h0c);
        rst_pulse();
        chk({7'h00, monitor_enable}, 8'h00);
        in_stop <= 1'b0;
        cyc(1);
        chk({7'h00, monitor_enable}, 8'h01);
        wr(`LVRC_ADDR_CONFIG, 8'h01);
        chk({7'h00, monitor_enable}, 8'h00);
        mv <= V_LOW;
        cyc(6);
        rd(`LVRC_ADDR_STATUS, 8'h00);
        rd(8'h05, 8'h00);
        end_of_test();
    end
endmodule // lvrc_tb_top
